// [pkg/stc_defines.svh]
// Register offsets, field positions, reset values and timing counts of the timing bank
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH

`define STC_BLOCK_BASE 9'h0C0
`define STC_OFF_GENERAL 9'h000
`define STC_OFF_DELAY 9'h001
`define STC_OFF_INTEG 9'h002
`define STC_OFF_WINDOW 9'h003
`define STC_OFF_RSVD 9'h004
`define STC_OFF_DARK 9'h005
`define STC_OFF_FILLER 9'h006
`define STC_OFF_MULT 9'h007
`define STC_OFF_SPAN 9'h008

`define STC_GEN_DLYEN_BIT 6
`define STC_GEN_AECWIN_BIT 10
`define STC_GEN_MON_LSB 11
`define STC_GEN_MON_MSB 13
`define STC_DLY_EXT_LSB 0
`define STC_DLY_EXT_MSB 7
`define STC_DLY_RD_LSB 8
`define STC_DLY_RD_MSB 15
`define STC_INT_DUAL_BIT 0
`define STC_INT_TRIPLE_BIT 1
`define STC_INT_KIND_BIT 2
`define STC_WIN_MSB 7
`define STC_DARK_MSB 7
`define STC_DARK_BLANK_BIT 8
`define STC_FILLER_MSB 11

`define STC_RST_DELAY 16'h0000
`define STC_RST_INTEG 16'h0004
`define STC_RST_WINDOW 16'h0001
`define STC_RST_DARK 16'h0102
`define STC_RST_FILLER 16'h0000
`define STC_RST_MULT 16'h0001
`define STC_RST_SPAN 16'h0000

`define STC_DARK_MIN 8'h01
`define STC_MULT_MIN 16'h0001

`endif

// [pkg/stc_pkg.sv]
// Types shared by the sequencer timing configuration bank
package stc_pkg;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_DARK = 2'b01,
        PH_FILLER = 2'b10,
        PH_IMAGE = 2'b11
    } stc_phase_t;

    typedef enum logic [2:0] {
        MON_OFF = 3'b000,
        MON_READOUT = 3'b001,
        MON_LINE = 3'b010,
        MON_PHASE = 3'b011,
        MON_EXPOSURE = 3'b100,
        MON_WINDOW = 3'b101,
        MON_SLOPE = 3'b110,
        MON_SPAN = 3'b111
    } stc_mon_t;

    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } stc_div_state_t;

endpackage

// [hw/stc_tick_divider.sv]
// Exposure timebase divider: one tick every period clocks while running
`timescale 1ns/100ps
`include "stc_defines.svh"
module stc_tick_divider #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic run,
    input wire logic [W-1:0] period,
    // Timebase
    output logic tick
);
    stc_pkg::stc_div_state_t st_r;
    stc_pkg::stc_div_state_t st_nxt;
    logic [W-1:0] periodEff;

    always_comb begin
        st_nxt = st_r;
        // A zero multiplier behaves as one clock per unit
        periodEff = (period == '0) ? W'(`STC_MULT_MIN) : period;
        st_nxt.tick = 1'b0;
        if (!run) begin
            st_nxt.count = '0;
        end else if (st_r.count >= periodEff - W'(1)) begin
            st_nxt.count = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.count = st_r.count + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule

// [hw/stc_timing_bank.sv]
// Sequencer timing configuration registers and the timing they steer
`timescale 1ns/100ps
`include "stc_defines.svh"
//
// Contract
// R1 - AEC statistics use all windows when bit clear, configured window when set.
// R2 - Three-bit monitor select chooses internal signals driven to monitor pins.
// R3 - Rolling shutter lines extended by eight-bit dummy pixel count, default zero.
// R4 - Programmable eight-bit wait between row overhead end and readout start.
// R5 - Dual slope enable, effective in global shutter only, resets to zero.
// R6 - Triple slope enable, effective in global shutter only, resets to zero.
// R7 - Length kind bit: 0 reset length, 1 frame length; resets to one.
// R8 - Dark row count 1 to 255, reset 2; zero is not allowed.
// R9 - First-row blanking bit blanks the first output line; resets to one.
// R10 - Rolling shutter only: twelve-bit filler row count, reset zero.
// R11 - Global shutter exposure counted in multiplier times clock units, reset one.
// R12 - Eight-bit active window mask, resets with only window zero selected.
// R13 - Readout delay inserted only while its enable bit is set.
// R14 - Sixteen-bit span used in global shutter only, meaning set by kind bit.
// R15 - Software writes reserved fields with defaults, ignores their read-back.
module stc_timing_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [8:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [15:0] regRdData,
    // Sequencer events
    input wire logic rollingShutter,
    input wire logic frameStart,
    input wire logic rowOverheadEnd,
    input wire logic lineReadoutEnd,
    input wire logic exposureRun,
    // Sequencer controls
    output logic readoutStart,
    output logic dummyPixelActive,
    output logic lineDone,
    output stc_pkg::stc_phase_t rowPhase,
    output logic firstLineBlank,
    output logic exposureTick,
    output logic dualSlopeOn,
    output logic tripleSlopeOn,
    output logic spanIsFrame,
    output logic [15:0] spanValue,
    output logic spanActive,
    output logic [7:0] activeWindows,
    output logic [7:0] statWindowMask,
    output logic [11:0] fillerRows,
    output logic [7:0] darkRows,
    // Monitor pins
    output logic [1:0] monitorPins
);

    typedef struct packed {
        // Configuration
        logic dlyEn;
        logic aecWin;
        logic [2:0] monSel;
        logic [7:0] lineExt;
        logic [7:0] rdDelay;
        logic dualSlope;
        logic tripleSlope;
        logic spanKind;
        logic [7:0] winSel;
        logic [7:0] darkCfg;
        logic blankFirst;
        logic [11:0] fillerCfg;
        logic [15:0] mult;
        logic [15:0] span;
        // Register read
        logic [15:0] rdData;
        // Readout delay
        logic dlyBusy;
        logic [7:0] dlyCnt;
        logic readoutStart;
        // Line extension
        logic extBusy;
        logic [7:0] extCnt;
        logic lineDone;
        // Row phases
        stc_pkg::stc_phase_t phase;
        logic [11:0] rowCnt;
        logic firstLine;
        logic firstLineBlank;
        // Registered views
        logic dualOn;
        logic tripleOn;
        logic spanActive;
        logic [7:0] statMask;
        logic [11:0] fillerEff;
        logic [7:0] darkEff;
        logic [1:0] monPins;
    } stc_bank_state_t;

    stc_bank_state_t st_r;
    stc_bank_state_t st_nxt;
    logic expTick;

    localparam logic [15:0] RST_DELAY = `STC_RST_DELAY;
    localparam logic [15:0] RST_INTEG = `STC_RST_INTEG;
    localparam logic [15:0] RST_WINDOW = `STC_RST_WINDOW;
    localparam logic [15:0] RST_DARK = `STC_RST_DARK;
    localparam logic [15:0] RST_FILLER = `STC_RST_FILLER;

    // Constant reset image: registers at their defaults, statMask all ones, darkEff at the dark default, everything else cleared
    localparam stc_bank_state_t RST_VAL = '{
        lineExt: RST_DELAY[`STC_DLY_EXT_MSB:`STC_DLY_EXT_LSB],
        rdDelay: RST_DELAY[`STC_DLY_RD_MSB:`STC_DLY_RD_LSB],
        dualSlope: RST_INTEG[`STC_INT_DUAL_BIT],
        tripleSlope: RST_INTEG[`STC_INT_TRIPLE_BIT],
        spanKind: RST_INTEG[`STC_INT_KIND_BIT],
        winSel: RST_WINDOW[`STC_WIN_MSB:0],
        darkCfg: RST_DARK[`STC_DARK_MSB:0],
        blankFirst: RST_DARK[`STC_DARK_BLANK_BIT],
        fillerCfg: RST_FILLER[`STC_FILLER_MSB:0],
        mult: `STC_RST_MULT,
        span: `STC_RST_SPAN,
        phase: stc_pkg::PH_IDLE,
        statMask: 8'hFF,
        darkEff: RST_DARK[`STC_DARK_MSB:0],
        default: '0
    };

    stc_tick_divider #(
        .W(16)
    ) u_exposure_tick (
        .clk(clk),
        .rst_b(rst_b),
        .run(exposureRun && !rollingShutter),  // R11
        .period(st_r.mult),  // R11
        .tick(expTick)
    );

    always_comb begin
        st_nxt = st_r;

        // Register writes; reserved bits are dropped and read back as zero
        if (regWrEn) begin
            unique case (regAddr)
                `STC_BLOCK_BASE + `STC_OFF_GENERAL: begin
                    st_nxt.dlyEn = regWrData[`STC_GEN_DLYEN_BIT];  // R13
                    st_nxt.aecWin = regWrData[`STC_GEN_AECWIN_BIT];  // R1
                    st_nxt.monSel = regWrData[`STC_GEN_MON_MSB:`STC_GEN_MON_LSB];  // R2
                end
                `STC_BLOCK_BASE + `STC_OFF_DELAY: begin
                    st_nxt.lineExt = regWrData[`STC_DLY_EXT_MSB:`STC_DLY_EXT_LSB];  // R3
                    st_nxt.rdDelay = regWrData[`STC_DLY_RD_MSB:`STC_DLY_RD_LSB];  // R4
                end
                `STC_BLOCK_BASE + `STC_OFF_INTEG: begin
                    st_nxt.dualSlope = regWrData[`STC_INT_DUAL_BIT];  // R5
                    st_nxt.tripleSlope = regWrData[`STC_INT_TRIPLE_BIT];  // R6
                    st_nxt.spanKind = regWrData[`STC_INT_KIND_BIT];  // R7
                end
                `STC_BLOCK_BASE + `STC_OFF_WINDOW: begin
                    st_nxt.winSel = regWrData[`STC_WIN_MSB:0];  // R12
                end
                `STC_BLOCK_BASE + `STC_OFF_DARK: begin
                    st_nxt.darkCfg = regWrData[`STC_DARK_MSB:0];  // R8
                    st_nxt.blankFirst = regWrData[`STC_DARK_BLANK_BIT];  // R9
                end
                `STC_BLOCK_BASE + `STC_OFF_FILLER: begin
                    st_nxt.fillerCfg = regWrData[`STC_FILLER_MSB:0];  // R10
                end
                `STC_BLOCK_BASE + `STC_OFF_MULT: begin
                    st_nxt.mult = regWrData;  // R11
                end
                `STC_BLOCK_BASE + `STC_OFF_SPAN: begin
                    st_nxt.span = regWrData;  // R14
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered on the next edge
        if (regRdEn) begin
            st_nxt.rdData = 16'h0000;
            unique case (regAddr)
                `STC_BLOCK_BASE + `STC_OFF_GENERAL: begin
                    st_nxt.rdData[`STC_GEN_DLYEN_BIT] = st_r.dlyEn;
                    st_nxt.rdData[`STC_GEN_AECWIN_BIT] = st_r.aecWin;
                    st_nxt.rdData[`STC_GEN_MON_MSB:`STC_GEN_MON_LSB] = st_r.monSel;
                end
                `STC_BLOCK_BASE + `STC_OFF_DELAY: begin
                    st_nxt.rdData = {st_r.rdDelay, st_r.lineExt};
                end
                `STC_BLOCK_BASE + `STC_OFF_INTEG: begin
                    st_nxt.rdData[`STC_INT_DUAL_BIT] = st_r.dualSlope;
                    st_nxt.rdData[`STC_INT_TRIPLE_BIT] = st_r.tripleSlope;
                    st_nxt.rdData[`STC_INT_KIND_BIT] = st_r.spanKind;
                end
                `STC_BLOCK_BASE + `STC_OFF_WINDOW: begin
                    st_nxt.rdData[`STC_WIN_MSB:0] = st_r.winSel;
                end
                `STC_BLOCK_BASE + `STC_OFF_DARK: begin
                    st_nxt.rdData[`STC_DARK_MSB:0] = st_r.darkCfg;
                    st_nxt.rdData[`STC_DARK_BLANK_BIT] = st_r.blankFirst;
                end
                `STC_BLOCK_BASE + `STC_OFF_FILLER: begin
                    st_nxt.rdData[`STC_FILLER_MSB:0] = st_r.fillerCfg;
                end
                `STC_BLOCK_BASE + `STC_OFF_MULT: begin
                    st_nxt.rdData = st_r.mult;
                end
                `STC_BLOCK_BASE + `STC_OFF_SPAN: begin
                    st_nxt.rdData = st_r.span;
                end
                default: begin
                end
            endcase
        end

        // Delay from end of row overhead to readout start
        st_nxt.readoutStart = 1'b0;
        if (st_r.dlyBusy) begin
            if (st_r.dlyCnt == 8'h01) begin
                st_nxt.dlyBusy = 1'b0;
                st_nxt.readoutStart = 1'b1;  // R4
            end
            st_nxt.dlyCnt = st_r.dlyCnt - 8'h01;
        end else if (rowOverheadEnd) begin
            if (st_r.dlyEn && st_r.rdDelay != 8'h00) begin  // R13
                st_nxt.dlyBusy = 1'b1;
                st_nxt.dlyCnt = st_r.rdDelay;  // R4
            end else begin
                st_nxt.readoutStart = 1'b1;  // R13
            end
        end

        // Dummy pixels appended to each rolling shutter line, one per clock
        st_nxt.lineDone = 1'b0;
        if (st_r.extBusy) begin
            if (st_r.extCnt == 8'h01) begin
                st_nxt.extBusy = 1'b0;
                st_nxt.lineDone = 1'b1;
            end
            st_nxt.extCnt = st_r.extCnt - 8'h01;
        end else if (lineReadoutEnd) begin
            if (rollingShutter && st_r.lineExt != 8'h00) begin  // R3
                st_nxt.extBusy = 1'b1;
                st_nxt.extCnt = st_r.lineExt;
            end else begin
                st_nxt.lineDone = 1'b1;
            end
        end

        // Effective row counts; zero dark rows is clamped to the minimum
        st_nxt.darkEff = (st_r.darkCfg == 8'h00) ? `STC_DARK_MIN : st_r.darkCfg;  // R8
        st_nxt.fillerEff = rollingShutter ? st_r.fillerCfg : 12'h000;  // R10

        // Row phases of a frame: dark rows, filler rows, image rows
        st_nxt.firstLineBlank = 1'b0;
        if (frameStart) begin
            st_nxt.phase = stc_pkg::PH_DARK;
            st_nxt.rowCnt = 12'h000;
        end else begin
            unique case (st_r.phase)
                stc_pkg::PH_IDLE: begin
                end
                stc_pkg::PH_DARK: begin
                    if (st_r.lineDone) begin
                        if (st_r.rowCnt + 12'h001 >= {4'h0, st_r.darkEff}) begin  // R8
                            st_nxt.rowCnt = 12'h000;
                            st_nxt.firstLine = 1'b1;
                            st_nxt.phase = (st_r.fillerEff != 12'h000) ?
                                stc_pkg::PH_FILLER : stc_pkg::PH_IMAGE;  // R10
                        end else begin
                            st_nxt.rowCnt = st_r.rowCnt + 12'h001;
                        end
                    end
                end
                stc_pkg::PH_FILLER: begin
                    if (st_r.lineDone) begin
                        if (st_r.rowCnt + 12'h001 >= st_r.fillerEff) begin  // R10
                            st_nxt.rowCnt = 12'h000;
                            st_nxt.phase = stc_pkg::PH_IMAGE;
                        end else begin
                            st_nxt.rowCnt = st_r.rowCnt + 12'h001;
                        end
                    end
                end
                stc_pkg::PH_IMAGE: begin
                    if (st_r.lineDone) begin
                        st_nxt.firstLine = 1'b0;
                    end
                end
            endcase
        end
        if (st_nxt.phase == stc_pkg::PH_IMAGE && st_nxt.firstLine && st_r.blankFirst) begin
            st_nxt.firstLineBlank = 1'b1;  // R9
        end

        // Global shutter only controls and the statistics window mask
        st_nxt.dualOn = st_r.dualSlope && !rollingShutter;  // R5
        st_nxt.tripleOn = st_r.tripleSlope && !rollingShutter;  // R6
        st_nxt.spanActive = !rollingShutter;  // R14
        st_nxt.statMask = st_r.aecWin ? st_r.winSel : 8'hFF;  // R1

        // Monitor pin source
        unique case (stc_pkg::stc_mon_t'(st_r.monSel))  // R2
            stc_pkg::MON_OFF: st_nxt.monPins = 2'b00;
            stc_pkg::MON_READOUT: st_nxt.monPins = {st_r.dlyBusy, st_r.readoutStart};
            stc_pkg::MON_LINE: st_nxt.monPins = {st_r.extBusy, st_r.lineDone};
            stc_pkg::MON_PHASE: st_nxt.monPins = st_r.phase;
            stc_pkg::MON_EXPOSURE: st_nxt.monPins = {exposureRun, expTick};
            stc_pkg::MON_WINDOW: st_nxt.monPins = {st_r.aecWin, st_r.firstLineBlank};
            stc_pkg::MON_SLOPE: st_nxt.monPins = {st_r.tripleOn, st_r.dualOn};
            stc_pkg::MON_SPAN: st_nxt.monPins = {st_r.spanActive, st_r.spanKind};
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= RST_VAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;
    assign readoutStart = st_r.readoutStart;
    assign dummyPixelActive = st_r.extBusy;
    assign lineDone = st_r.lineDone;
    assign rowPhase = st_r.phase;
    assign firstLineBlank = st_r.firstLineBlank;
    assign exposureTick = expTick;
    assign dualSlopeOn = st_r.dualOn;
    assign tripleSlopeOn = st_r.tripleOn;
    assign spanIsFrame = st_r.spanKind;  // R7
    assign spanValue = st_r.span;
    assign spanActive = st_r.spanActive;
    assign activeWindows = st_r.winSel;
    assign statWindowMask = st_r.statMask;
    assign fillerRows = st_r.fillerEff;
    assign darkRows = st_r.darkEff;
    assign monitorPins = st_r.monPins;
endmodule

// [tb/stc_timing_bank_sva.sv]
// Port assertions for the sequencer timing bank
`timescale 1ns/100ps
module stc_timing_bank_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Sequencer events
    input wire logic rollingShutter,
    input wire logic lineReadoutEnd,
    input wire logic exposureRun,
    // Sequencer controls
    input wire logic readoutStart,
    input wire logic dummyPixelActive,
    input wire logic lineDone,
    input wire stc_pkg::stc_phase_t rowPhase,
    input wire logic firstLineBlank,
    input wire logic exposureTick,
    input wire logic dualSlopeOn,
    input wire logic tripleSlopeOn,
    input wire logic spanActive,
    input wire logic [11:0] fillerRows,
    input wire logic [7:0] darkRows
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_RD_ONE: assert property (readoutStart |=> !readoutStart)
        else $error("readout start held longer than one cycle");
    AST_DUAL_GS: assert property (dualSlopeOn |-> !$past(rollingShutter))
        else $error("dual slope on in rolling shutter");
    AST_TRIPLE_GS: assert property (tripleSlopeOn |-> !$past(rollingShutter))
        else $error("triple slope on in rolling shutter");
    AST_SPAN_ACT: assert property ($past(rst_b) |-> spanActive == !$past(rollingShutter))
        else $error("span active does not follow shutter mode");
    AST_FILLER_GS: assert property ($past(rst_b) && !$past(rollingShutter) |->
        fillerRows == 12'h000)
        else $error("filler rows nonzero in global shutter");
    AST_DARK_MIN: assert property (darkRows != 8'h00)
        else $error("dark row count zero");
    AST_DUMMY_RS: assert property (dummyPixelActive |-> $past(rollingShutter))
        else $error("dummy pixels in global shutter");
    AST_LINE_GS: assert property (lineReadoutEnd && !rollingShutter && !dummyPixelActive
        |=> lineDone)
        else $error("global shutter line not done next cycle");
    AST_TICK_RUN: assert property (exposureTick |-> $past(exposureRun) &&
        !$past(rollingShutter))
        else $error("exposure tick without running global exposure");
    AST_BLANK_IMG: assert property (firstLineBlank |-> rowPhase == stc_pkg::PH_IMAGE)
        else $error("first line blank outside image rows");
endmodule

bind stc_timing_bank stc_timing_bank_sva i_stc_timing_bank_sva (.clk, .rst_b,
    .rollingShutter, .lineReadoutEnd, .exposureRun, .readoutStart, .dummyPixelActive,
    .lineDone, .rowPhase, .firstLineBlank, .exposureTick, .dualSlopeOn, .tripleSlopeOn,
    .spanActive, .fillerRows, .darkRows);

// [tb/stc_timing_bank_bench.sv]
// Self-checking bench for the sequencer timing configuration bank
`timescale 1ns/100ps
`include "stc_defines.svh"
module stc_timing_bank_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [8:0] regAddr = 9'h000;
    logic [15:0] regWrData = 16'h0000;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic rollingShutter = 1'b0;
    logic frameStart = 1'b0;
    logic rowOverheadEnd = 1'b0;
    logic lineReadoutEnd = 1'b0;
    logic exposureRun = 1'b0;
    logic readoutStart, dummyPixelActive, lineDone, firstLineBlank, exposureTick;
    logic dualSlopeOn, tripleSlopeOn, spanIsFrame, spanActive;
    logic [15:0] regRdData, spanValue;
    logic [7:0] activeWindows, statWindowMask, darkRows;
    logic [11:0] fillerRows;
    logic [1:0] monitorPins;
    stc_pkg::stc_phase_t rowPhase;
    int n_fail = 0;
    int cmp_count = 0;
    int n, d;
    logic [15:0] rstVal [8] = '{16'h0000, 16'h0004, 16'h0001, 16'h0000,
        16'h0102, 16'h0000, 16'h0001, 16'h0000};
    logic [15:0] wrMask [8] = '{16'hFFFF, 16'h0007, 16'h00FF, 16'h0000,
        16'h01FF, 16'h0FFF, 16'hFFFF, 16'hFFFF};

    always #2 clk = ~clk;

    stc_timing_bank i_stc_timing_bank (.clk, .rst_b, .regAddr, .regWrData, .regWrEn,
        .regRdEn, .regRdData, .rollingShutter, .frameStart, .rowOverheadEnd,
        .lineReadoutEnd, .exposureRun, .readoutStart, .dummyPixelActive, .lineDone,
        .rowPhase, .firstLineBlank, .exposureTick, .dualSlopeOn, .tripleSlopeOn,
        .spanIsFrame, .spanValue, .spanActive, .activeWindows, .statWindowMask,
        .fillerRows, .darkRows, .monitorPins);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic wr(input logic [8:0] off, input logic [15:0] data);
        @(negedge clk);
        regAddr = `STC_BLOCK_BASE + off;
        regWrData = data;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask

    task automatic rd(input logic [8:0] off, input logic [15:0] exp);
        @(negedge clk);
        regAddr = `STC_BLOCK_BASE + off;
        regRdEn = 1'b1;
        @(negedge clk);
        regRdEn = 1'b0;
        check(regRdData, exp);
    endtask

    function automatic logic seen(input int sel);
        return sel == 0 ? readoutStart : (sel == 1 ? lineDone : exposureTick);
    endfunction

    // Cycles from the taken edge to the answer, and dummy cycles meanwhile
    task automatic measure(input int sel, output int n, output int d);
        @(negedge clk);
        if (sel == 0) rowOverheadEnd = 1'b1;
        else if (sel == 1) lineReadoutEnd = 1'b1;
        else exposureRun = 1'b1;
        @(negedge clk);
        rowOverheadEnd = 1'b0;
        lineReadoutEnd = 1'b0;
        n = 1;
        d = 0;
        while (seen(sel) !== 1'b1) begin
            if (dummyPixelActive === 1'b1) d++;
            if (n == 300) begin
                n_fail++;
                test_done();
            end
            @(negedge clk);
            n++;
        end
    endtask

    task automatic dly_case(input logic [15:0] g, input logic [15:0] dl, input int e);
        wr(9'h000, g);
        wr(9'h001, dl);
        measure(0, n, d);
        check(16'(n), 16'(e));
    endtask

    task automatic line_case(input logic rs, input logic [15:0] dl, input int en, input int ed);
        rollingShutter = rs;
        wr(9'h001, dl);
        measure(1, n, d);
        check(16'(n), 16'(en));
        check(16'(d), 16'(ed));
    endtask

    task automatic next_line(input stc_pkg::stc_phase_t ph, input logic blank);
        measure(1, n, d);
        idle(1);
        check(rowPhase, ph);
        check(firstLineBlank, blank);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 8; i++) rd(9'(i + 1), rstVal[i]);
        rd(9'h000, 16'h0000);
        rd(9'h009, 16'h0000);
        rd(9'h1FF, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(9'(i + 1), wrMask[i]);
            rd(9'(i + 1), wrMask[i]);
        end
        wr(9'h000, 16'h3C40);
        rd(9'h000, 16'h3C40);
        wr(9'h009, 16'hFFFF);
        rd(9'h009, 16'h0000);
        // Second reset in mid-run restores defaults
        rst_b = 1'b0;
        idle(2);
        rst_b = 1'b1;
        rd(9'h002, 16'h0004);
        check(darkRows, 16'h0002);
        check(spanIsFrame, 16'h0001);
        check(activeWindows, 16'h0001);
        dly_case(16'h0040, 16'h0200, 3);
        dly_case(16'h0000, 16'h0200, 1);
        dly_case(16'h0040, 16'h0000, 1);
        dly_case(16'h0040, 16'hFF00, 256);
        line_case(1'b1, 16'h0001, 2, 1);
        line_case(1'b1, 16'h00FF, 256, 255);
        line_case(1'b0, 16'h0003, 1, 0);
        wr(9'h007, 16'h0003);
        measure(2, n, d);
        check(16'(n), 16'h0003);
        d = 0;
        repeat (9) begin
            @(negedge clk);
            if (exposureTick === 1'b1) d++;
        end
        exposureRun = 1'b0;
        check(16'(d), 16'h0003);
        wr(9'h002, 16'h0003);
        wr(9'h000, 16'h3000);
        idle(3);
        check(dualSlopeOn, 16'h0001);
        check(tripleSlopeOn, 16'h0001);
        check(spanIsFrame, 16'h0000);
        check(monitorPins, 16'h0003);
        rollingShutter = 1'b1;
        idle(3);
        check(dualSlopeOn, 16'h0000);
        check(tripleSlopeOn, 16'h0000);
        check(spanActive, 16'h0000);
        wr(9'h000, 16'h0000);
        idle(3);
        check(monitorPins, 16'h0000);
        wr(9'h003, 16'h00A5);
        idle(2);
        check(activeWindows, 16'h00A5);
        check(statWindowMask, 16'h00FF);
        wr(9'h000, 16'h0400);
        idle(2);
        check(statWindowMask, 16'h00A5);
        wr(9'h006, 16'h0FFF);
        idle(2);
        check(fillerRows, 16'h0FFF);
        rollingShutter = 1'b0;
        wr(9'h005, 16'h0000);
        wr(9'h008, 16'hBEEF);
        idle(2);
        check(fillerRows, 16'h0000);
        check(darkRows, 16'h0001);
        check(spanValue, 16'hBEEF);
        check(spanActive, 16'h0001);
        rollingShutter = 1'b1;
        wr(9'h001, 16'h0000);
        wr(9'h005, 16'h0101);
        wr(9'h006, 16'h0001);
        idle(2);
        frameStart = 1'b1;
        @(negedge clk);
        frameStart = 1'b0;
        check(rowPhase, stc_pkg::PH_DARK);
        next_line(stc_pkg::PH_FILLER, 1'b0);
        next_line(stc_pkg::PH_IMAGE, 1'b1);
        next_line(stc_pkg::PH_IMAGE, 1'b0);
        wr(9'h000, 16'h1800);
        idle(3);
        check(monitorPins, 16'h0003);
        wr(9'h000, 16'h2C00);
        idle(3);
        check(monitorPins, 16'h0002);
        test_done();
    end
endmodule
